// file: rtl/staged_boot_and_runtime_watchdog.sv
// What this block does
// - boot watchdog timeout off, 30s, 1, 2, 5, 10 or 30 minutes
// - boot watchdog counts only during self test, resets on expiry
// - optionally hold boot watchdog during boot popup or password wait
// - runtime modes off, single-service, one-pass, repeat; armed at OS start
// - single-service mode disables itself on first service
// - one-pass mode runs each configured stage once, then disables
// - repeat mode re-runs final stage until system reset
// - runtime start delay none, 10s, 30s, 1, 2, 5, 10 or 30 minutes
// - stage one always enabled, raises notify, reset or power button
// - stages two and three may be off or raise any event
// - each stage timeout 1..30 seconds or 1..30 minutes, independent
// - notify event requests critical shutdown or restart, by configuration
// - shutdown notification signals over-temperature to the OS
// - restart notification reports fatal platform error to the OS
`timescale 1ns/1ps
`include "sbw_map.svh"
module staged_boot_and_runtime_watchdog #(
    parameter int CLK_HZ = 40_000_000,
    // cycles per second; shorten for simulation
    parameter logic [31:0] TICK_CYCLES = 32'(CLK_HZ)
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system actions
    output sbw_pkg::sbw_action_type action,
    output logic irq
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001, ST_DELAY = 5'b00010, ST_STAGE = 5'b00100,
        ST_DONE = 5'b01000, ST_OFF = 5'b10000
    } sbw_state_type;

    sbw_pkg::sbw_cfg_type cfg_r;
    logic [4:0] ctrl_r;
    logic bootRun_r;
    logic [31:0] tickCnt_r;
    logic tick;
    logic [11:0] bootSec_r;
    logic [11:0] runSec_r;
    sbw_state_type state_r;
    logic [1:0] stage_r;
    logic [`SBW_IRQ_WIDTH-1:0] irqStat_r;
    logic [`SBW_IRQ_WIDTH-1:0] irqMask_r;
    logic [`SBW_IRQ_WIDTH-1:0] irqSet;
    logic [`SBW_IRQ_WIDTH-1:0] irqClr;
    sbw_pkg::sbw_action_type action_nxt;
    logic wrEn;
    logic service;
    logic bootExpire;
    logic stageExpire;
    logic [1:0] nextStage;
    logic nextValid;
    logic [1:0] curEvent;
    logic [31:0] statusWord;

    function automatic logic [11:0] stageSecs(input logic [3:0] sel);
        unique case (sel)
            4'h0: stageSecs = 12'h001;
            4'h1: stageSecs = 12'h002;
            4'h2: stageSecs = 12'h005;
            4'h3: stageSecs = 12'h00A;
            4'h4: stageSecs = 12'h01E;
            4'h5: stageSecs = 12'h03C;
            4'h6: stageSecs = 12'h078;
            4'h7: stageSecs = 12'h12C;
            4'h8: stageSecs = 12'h258;
            default: stageSecs = 12'h708;
        endcase
    endfunction : stageSecs

    function automatic logic [1:0] stageEvent(input sbw_pkg::sbw_cfg_type c,
                                              input logic [1:0] s);
        unique case (s)
            2'h0: stageEvent = c.ev1;
            2'h1: stageEvent = c.ev2;
            default: stageEvent = c.ev3;
        endcase
    endfunction : stageEvent

    function automatic logic [3:0] stageTmo(input sbw_pkg::sbw_cfg_type c,
                                            input logic [1:0] s);
        unique case (s)
            2'h0: stageTmo = c.tmo1;
            2'h1: stageTmo = c.tmo2;
            default: stageTmo = c.tmo3;
        endcase
    endfunction : stageTmo

    // boot codes map onto the stage table, 30s is code 4
    function automatic logic [11:0] bootSecs(input logic [2:0] sel);
        bootSecs = stageSecs(4'(sel) + 4'h3);
    endfunction : bootSecs

    function automatic logic [11:0] delaySecs(input logic [2:0] sel);
        delaySecs = stageSecs(4'(sel) + 4'h2);
    endfunction : delaySecs

    // one decode for every register write strobe
    function automatic logic wrHit(input logic en, input logic [11:0] a,
                                   input logic [11:0] target);
        wrHit = en && a == target;
    endfunction : wrHit

    assign wrEn = psel && penable && pwrite;
    assign service = wrHit(wrEn, paddr, `SBW_ADDR_SERVICE) && pwdata == `SBW_SERVICE_KEY;
    assign tick = tickCnt_r == TICK_CYCLES - 32'h0000_0001;
    // status layout: boot seconds left, stage, boot running, state
    assign statusWord = {8'h00, bootSec_r, 2'b00, stage_r, 1'b0, bootRun_r, 1'b0, state_r};

    // free-running, so a restart may see its first second cut short
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            tickCnt_r <= 32'h0000_0000;
        else if (tick)
            tickCnt_r <= 32'h0000_0000;
        else
            tickCnt_r <= tickCnt_r + 32'h0000_0001;
    end

    // apb: zero wait states, unmapped addresses answer with slverr
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_r <= '0;
            ctrl_r <= 5'h00;
            irqMask_r <= '0;
        end
        else
        begin
            if (wrHit(wrEn, paddr, `SBW_ADDR_CFG))
                cfg_r <= sbw_pkg::sbw_cfg_type'(pwdata[$bits(sbw_pkg::sbw_cfg_type)-1:0]);
            if (wrHit(wrEn, paddr, `SBW_ADDR_CTRL))
                ctrl_r <= pwdata[4:0];
            else
            begin
                // start, done and os-start bits are self-clearing pulses
                ctrl_r[`SBW_CTRL_BOOT_START] <= 1'b0;
                ctrl_r[`SBW_CTRL_BOOT_DONE] <= 1'b0;
                ctrl_r[`SBW_CTRL_OS_START] <= 1'b0;
            end
            if (wrHit(wrEn, paddr, `SBW_ADDR_IRQ_MASK))
                irqMask_r <= pwdata[`SBW_IRQ_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable)
            begin
                unique case (paddr)
                    `SBW_ADDR_CTRL: prdata <= 32'(ctrl_r);
                    `SBW_ADDR_CFG: prdata <= 32'(cfg_r);
                    `SBW_ADDR_SERVICE: prdata <= 32'h0000_0000;
                    `SBW_ADDR_STATUS: prdata <= statusWord;
                    `SBW_ADDR_IRQ_STAT: prdata <= 32'(irqStat_r);
                    `SBW_ADDR_IRQ_MASK: prdata <= 32'(irqMask_r);
                    `SBW_ADDR_STATE: prdata <= {20'h0_0000, runSec_r};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // boot watchdog
    assign bootExpire = bootRun_r && tick && bootSec_r == 12'h001
        && !(ctrl_r[`SBW_CTRL_HOLD_EN] && ctrl_r[`SBW_CTRL_HOLD]);

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bootRun_r <= 1'b0;
            bootSec_r <= 12'h000;
        end
        else if (ctrl_r[`SBW_CTRL_BOOT_START] && cfg_r.bootSel != 3'h0)
        begin
            bootRun_r <= 1'b1;
            bootSec_r <= bootSecs(cfg_r.bootSel);
        end
        else if (ctrl_r[`SBW_CTRL_BOOT_DONE] || bootExpire)
            bootRun_r <= 1'b0;
        else if (bootRun_r && tick && !(ctrl_r[`SBW_CTRL_HOLD_EN] && ctrl_r[`SBW_CTRL_HOLD]))
            bootSec_r <= bootSec_r - 12'h001;
    end

    // runtime watchdog
    assign curEvent = stageEvent(cfg_r, stage_r);
    assign stageExpire = state_r == ST_STAGE && tick && runSec_r == 12'h001;

    // next enabled stage; stage one is never skipped
    always_comb
    begin
        nextValid = 1'b0;
        nextStage = stage_r;
        if (stage_r == 2'h0 && cfg_r.ev2 != 2'(sbw_pkg::EV_OFF))
        begin
            nextValid = 1'b1;
            nextStage = 2'h1;
        end
        else if (stage_r != 2'h2 && cfg_r.ev3 != 2'(sbw_pkg::EV_OFF))
        begin
            nextValid = 1'b1;
            nextStage = 2'h2;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= ST_IDLE;
            stage_r <= 2'h0;
            runSec_r <= 12'h000;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE, ST_OFF, ST_DONE:
                    if (ctrl_r[`SBW_CTRL_OS_START])
                    begin
                        if (cfg_r.runMode == 2'(sbw_pkg::RUN_OFF))
                            state_r <= ST_OFF;
                        else if (cfg_r.delaySel == 3'h0)
                        begin
                            state_r <= ST_STAGE;
                            stage_r <= 2'h0;
                            runSec_r <= stageSecs(cfg_r.tmo1);
                        end
                        else
                        begin
                            state_r <= ST_DELAY;
                            runSec_r <= delaySecs(cfg_r.delaySel);
                        end
                    end
                ST_DELAY:
                    if (tick && runSec_r == 12'h001)
                    begin
                        state_r <= ST_STAGE;
                        stage_r <= 2'h0;
                        runSec_r <= stageSecs(cfg_r.tmo1);
                    end
                    else if (tick)
                        runSec_r <= runSec_r - 12'h001;
                ST_STAGE:
                    // a service in the same cycle as an expiry decides the next state, but the expiry's action still pulses
                    if (service && cfg_r.runMode == 2'(sbw_pkg::RUN_SINGLE))
                        state_r <= ST_OFF;
                    else if (service)
                    begin
                        stage_r <= 2'h0;
                        runSec_r <= stageSecs(cfg_r.tmo1);
                    end
                    else if (stageExpire && nextValid)
                    begin
                        stage_r <= nextStage;
                        runSec_r <= stageSecs(stageTmo(cfg_r, nextStage));
                    end
                    else if (stageExpire && cfg_r.runMode == 2'(sbw_pkg::RUN_REPEAT))
                        runSec_r <= stageSecs(stageTmo(cfg_r, stage_r));
                    else if (stageExpire)
                        state_r <= ST_DONE;
                    else if (tick)
                        runSec_r <= runSec_r - 12'h001;
            endcase
        end
    end

    // actions: one-cycle pulses
    always_comb
    begin
        action_nxt = '0;
        if (bootExpire)
            action_nxt.sysReset = 1'b1;
        if (stageExpire)
        begin
            unique case (curEvent)
                2'(sbw_pkg::EV_NOTIFY):
                begin
                    action_nxt.overTemp = !cfg_r.notifyRestart;
                    action_nxt.fatalError = cfg_r.notifyRestart;
                end
                2'(sbw_pkg::EV_RESET): action_nxt.sysReset = 1'b1;
                2'(sbw_pkg::EV_PWRBTN): action_nxt.pwrButton = 1'b1;
                default: ; // stage one coded off still acts as a reset
            endcase
            if (stage_r == 2'h0 && curEvent == 2'(sbw_pkg::EV_OFF))
                action_nxt.sysReset = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            action <= '0;
        else
            action <= action_nxt;
    end

    // interrupts: set wins over write-one-to-clear
    assign irqSet = {action_nxt.pwrButton, action_nxt.sysReset,
                     action_nxt.overTemp | action_nxt.fatalError, stageExpire, bootExpire};
    assign irqClr = wrHit(wrEn, paddr, `SBW_ADDR_IRQ_STAT) ? pwdata[`SBW_IRQ_WIDTH-1:0] : '0;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irqStat_r <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
            // built from the updated status so irq rises with the bit
            irq <= |(((irqStat_r & ~irqClr) | irqSet) & irqMask_r);
        end
    end
endmodule : staged_boot_and_runtime_watchdog

// file: rtl/sbw_map.svh
`ifndef SBW_MAP_SVH
`define SBW_MAP_SVH
`define SBW_ADDR_CTRL 12'h000
`define SBW_ADDR_CFG 12'h004
`define SBW_ADDR_SERVICE 12'h008
`define SBW_ADDR_STATUS 12'h00C
`define SBW_ADDR_IRQ_STAT 12'h010
`define SBW_ADDR_IRQ_MASK 12'h014
`define SBW_ADDR_STATE 12'h018
`define SBW_SERVICE_KEY 32'h0000_5A5A
`define SBW_CTRL_BOOT_START 0
`define SBW_CTRL_BOOT_DONE 1
`define SBW_CTRL_HOLD 2
`define SBW_CTRL_OS_START 3
`define SBW_CTRL_HOLD_EN 4
`define SBW_IRQ_BOOT 0
`define SBW_IRQ_STAGE 1
`define SBW_IRQ_NOTIFY 2
`define SBW_IRQ_RESET 3
`define SBW_IRQ_PWRBTN 4
`define SBW_IRQ_WIDTH 5
`define SBW_US_PER_SEC 32'h000F_4240
`endif

// file: rtl/sbw_pkg.sv
package sbw_pkg;
    typedef enum logic [1:0] {
        RUN_OFF = 2'h0, RUN_SINGLE = 2'h1, RUN_ONEPASS = 2'h2, RUN_REPEAT = 2'h3
    } sbw_run_mode_type;
    typedef enum logic [1:0] {
        EV_OFF = 2'h0, EV_NOTIFY = 2'h1, EV_RESET = 2'h2, EV_PWRBTN = 2'h3
    } sbw_event_type;
    // timeout select codes: 0..4 = 1,2,5,10,30 s; 5..9 = 1,2,5,10,30 min
    typedef struct packed {
        logic [2:0] bootSel;      // 0 off, 1..6 = 30s,1m,2m,5m,10m,30m
        logic [1:0] runMode;
        logic [2:0] delaySel;     // 0 none, 1..7 = 10s,30s,1m,2m,5m,10m,30m
        logic [1:0] ev1;
        logic [1:0] ev2;
        logic [1:0] ev3;
        logic [3:0] tmo1;
        logic [3:0] tmo2;
        logic [3:0] tmo3;
        logic notifyRestart;
    } sbw_cfg_type;
    typedef struct packed {
        logic sysReset;
        logic pwrButton;
        logic overTemp;
        logic fatalError;
    } sbw_action_type;
endpackage : sbw_pkg

// file: tb/sbw_monitor.sv
`timescale 1ns/1ps
module sbw_monitor (
    // clock and reset
    input logic sys_clk,
    input logic resetn,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // system actions
    input sbw_pkg::sbw_action_type action,
    input logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_quiet; $rose(resetn) |-> action == 4'h0 && !irq && !pready; endproperty
    a_quiet: assert property (p_quiet)
        else $error("outputs active right after reset");
    property p_rst_pls; action.sysReset |=> !action.sysReset; endproperty
    a_rst_pls: assert property (p_rst_pls)
        else $error("system reset pulse too long");
    property p_pwr_pls; action.pwrButton |=> !action.pwrButton; endproperty
    a_pwr_pls: assert property (p_pwr_pls)
        else $error("power button pulse too long");
    property p_hot_pls; action.overTemp |=> !action.overTemp; endproperty
    a_hot_pls: assert property (p_hot_pls)
        else $error("over temperature pulse too long");
    property p_fatal_pls; action.fatalError |=> !action.fatalError; endproperty
    a_fatal_pls: assert property (p_fatal_pls)
        else $error("fatal error pulse too long");
    property p_one_evt; $onehot0(action); endproperty
    a_one_evt: assert property (p_one_evt)
        else $error("more than one action at once");
    property p_answer; psel && !penable |=> pready; endproperty
    a_answer: assert property (p_answer)
        else $error("bus access not answered");
    property p_unmapped; psel && penable && pready && paddr > 12'h018 |-> pslverr && prdata == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
endmodule : sbw_monitor

// file: tb/sbw_host.sv
`timescale 1ns/1ps
`include "sbw_map.svh"
module sbw_host (
    // clock
    input logic sys_clk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr
);
    // bus idles before the first transfer
    initial
    begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // stale lines inverted so a late sample cannot pass by luck
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer

    task automatic service();
        logic [31:0] r;
        logic e;
        xfer(1'b1, `SBW_ADDR_SERVICE, `SBW_SERVICE_KEY, r, e);
    endtask : service
endmodule : sbw_host

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "sbw_map.svh"
module testbench;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, rdErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    sbw_pkg::sbw_action_type action;
    sbw_pkg::sbw_action_type expQ[$];
    sbw_pkg::sbw_cfg_type cfg;
    int errors = 0;
    int totalChecks = 0;
    int cycles = 0;
    int seed = 32'h0000_58F2;

    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    staged_boot_and_runtime_watchdog #(.TICK_CYCLES(32'h0000_000A)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .action(action), .irq(irq));
    sbw_host host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s exp=%h seen=%h", name, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdData, rdErr);
    endtask : wr

    task automatic arm(input sbw_pkg::sbw_cfg_type c);
        wr(`SBW_ADDR_CFG, 32'(c));
        wr(`SBW_ADDR_CTRL, 32'h0000_0008);
    endtask : arm

    task automatic drain(input int lim);
        int n;
        n = 0;
        while (expQ.size() != 0 && n < lim)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk("pending events", 32'(expQ.size()), 32'h0000_0000);
    endtask : drain

    always @(posedge sys_clk)
    begin
        if (resetn && action !== 4'h0)
        begin
            if (expQ.size() == 0)
                chk("unexpected event", 32'(action), 32'h0000_0000);
            else
                chk("event", 32'(action), 32'(expQ.pop_front()));
        end
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        host.xfer(1'b0, `SBW_ADDR_IRQ_STAT, 32'h0000_0000, rdData, rdErr);
        chk("irq status", rdData, 32'h0000_0000);
        chk("mapped accepted", {31'h0000_0000, rdErr}, 32'h0000_0000);
        wr(12'h01C, $random(seed));
        chk("unmapped refused", {31'h0000_0000, rdErr}, 32'h0000_0001);
        wr(`SBW_ADDR_IRQ_MASK, 32'h0000_001F);
        $display("registers done");
        cfg = '0;
        cfg.bootSel = 3'h1;
        wr(`SBW_ADDR_CFG, 32'(cfg));
        // start held, then released, then self test ends before expiry
        wr(`SBW_ADDR_CTRL, 32'h0000_0015);
        repeat (400) @(posedge sys_clk);
        wr(`SBW_ADDR_CTRL, 32'h0000_0010);
        repeat (100) @(posedge sys_clk);
        wr(`SBW_ADDR_CTRL, 32'h0000_0002);
        repeat (400) @(posedge sys_clk);
        wr(`SBW_ADDR_CTRL, 32'h0000_0001);
        expQ.push_back(4'h8);
        repeat (280) @(posedge sys_clk);
        chk("boot not yet expired", 32'(expQ.size()), 32'h0000_0001);
        drain(100);
        repeat (2) @(posedge sys_clk);
        chk("irq raised", {31'h0000_0000, irq}, 32'h0000_0001);
        wr(`SBW_ADDR_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        chk("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
        wr(`SBW_ADDR_IRQ_STAT, 32'h0000_001F);
        wr(`SBW_ADDR_IRQ_MASK, 32'h0000_001F);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
        $display("boot watchdog done");
        cfg = '0;
        cfg.runMode = sbw_pkg::RUN_ONEPASS;
        cfg.ev1 = sbw_pkg::EV_NOTIFY;
        cfg.ev2 = sbw_pkg::EV_PWRBTN;
        cfg.ev3 = sbw_pkg::EV_RESET;
        cfg.tmo1 = {3'h0, 1'($random(seed))};
        cfg.tmo2 = {3'h0, 1'($random(seed))};
        cfg.tmo3 = {3'h0, 1'($random(seed))};
        arm(cfg);
        expQ.push_back(4'h2);
        expQ.push_back(4'h4);
        expQ.push_back(4'h8);
        drain(200);
        repeat (200) @(posedge sys_clk);
        $display("one pass done");
        cfg.runMode = sbw_pkg::RUN_REPEAT;
        cfg.ev2 = sbw_pkg::EV_OFF;
        cfg.ev3 = sbw_pkg::EV_PWRBTN;
        cfg.notifyRestart = 1'b1;
        arm(cfg);
        expQ.push_back(4'h1);
        repeat (3) expQ.push_back(4'h4);
        drain(300);
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        $display("repeat done");
        cfg = '0;
        cfg.runMode = sbw_pkg::RUN_ONEPASS;
        cfg.delaySel = 3'h1;
        cfg.ev1 = sbw_pkg::EV_RESET;
        arm(cfg);
        expQ.push_back(4'h8);
        repeat (90) @(posedge sys_clk);
        chk("still in delay", 32'(expQ.size()), 32'h0000_0001);
        drain(100);
        cfg.delaySel = 3'h0;
        cfg.ev1 = sbw_pkg::EV_PWRBTN;
        cfg.tmo1 = 4'h1;
        arm(cfg);
        repeat (20) host.service();
        expQ.push_back(4'h4);
        drain(100);
        cfg.runMode = sbw_pkg::RUN_OFF;
        arm(cfg);
        host.xfer(1'b0, `SBW_ADDR_STATUS, 32'h0000_0000, rdData, rdErr);
        chk("runtime off", rdData, 32'h0000_0010);
        cfg.runMode = sbw_pkg::RUN_SINGLE;
        arm(cfg);
        host.service();
        repeat (300) @(posedge sys_clk);
        chk("single service quiet", 32'(expQ.size()), 32'h0000_0000);
        host.xfer(1'b0, `SBW_ADDR_STATUS, 32'h0000_0000, rdData, rdErr);
        chk("single service off", rdData, 32'h0000_0010);
        $display("runtime service done");
        tally_and_finish();
    end
endmodule : testbench

bind staged_boot_and_runtime_watchdog sbw_monitor mon (.sys_clk(sys_clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .action(action), .irq(irq));
